/* File: verilog/adcssp_pkg.sv */
// Operation
// RQ1: Host without busy uses clock mode 0
// RQ2: Trigger rise starts conversion, releases output
// RQ3: Conversion completes regardless of trigger
// RQ4: Host holds trigger high through conversion
// RQ5: Trigger low after conversion shows MSB
// RQ6: Host presents config MSB at trigger fall
// RQ7: Plain mode: 14 captures, 15 shifts
// RQ8: Incomplete config ignored; transfers before window
// RQ9: Unread result replaced by next result
// RQ10: Plain mode releases on edge 16/30
// RQ11: Readback follows result, MSB first
// RQ12: Host with busy uses clock mode 3
// RQ13: Host holds trigger low through conversion
// RQ14: Busy mode drives output low at end
// RQ15: Busy mode: 14 captures, 16 shifts
// RQ16: Busy mode transfers finish before window
// RQ17: Busy mode releases on edge 17/31
// RQ18: Busy readback LSB on edge 30
// RQ19: Without release edge last bit stays
// RQ20: Config applied only at conversion end
// RQ21: First results undefined after power-up
// RQ22: Config held then copied when complete
package adcssp_pkg;
  localparam int CFG_W = 14;
  localparam int RES_W = 16;
  localparam int STREAM_W = RES_W + CFG_W;
  localparam int FALL_CNT_W = 5;
  localparam int RISE_CNT_W = 4;
  localparam logic [FALL_CNT_W-1:0] REL_PLAIN = 5'h10;
  localparam logic [FALL_CNT_W-1:0] REL_PLAIN_RB = 5'h1E;
  localparam logic [FALL_CNT_W-1:0] REL_BUSY = 5'h11;
  localparam logic [FALL_CNT_W-1:0] REL_BUSY_RB = 5'h1F;
  localparam logic [FALL_CNT_W-1:0] FALL_MAX = 5'h1F;
  localparam logic [RISE_CNT_W-1:0] RISE_DONE = 4'hE;
  localparam int CFG_RB_BIT = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 14'h0000;
  localparam logic [RES_W-1:0] RES_RESET = 16'h0000;
  localparam int SYS_CLK_MHZ = 100;
  localparam int CONV_TIME_NS = 2200;
  localparam int CONV_CYCLES = (CONV_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CONV_CNT_W = 12;
  typedef enum logic [0:0] {ST_IDLE, ST_CONV} adcssp_state_t;
endpackage

/* File: verilog/adcssp_link_if.sv */
`timescale 1ns/1ps
interface adcssp_link_if;
  import adcssp_pkg::*;
  logic [CFG_W-1:0] cfg_word;
  logic cfg_tgl;
  logic [FALL_CNT_W-1:0] fall_cnt;
  modport link (output cfg_word, output cfg_tgl, output fall_cnt);
  modport core (input cfg_word, input cfg_tgl, input fall_cnt);
endinterface

/* File: verilog/adcssp_link.sv */
`timescale 1ns/1ps
module adcssp_link (
  // Link clock and clears
  input wire logic serial_clk,
  input wire logic rst_n,
  input wire logic conv_trigger,
  input wire logic eoc_clr,
  // Serial data in
  input wire logic serial_in,
  // Toward core
  adcssp_link_if.link lnk
);
  import adcssp_pkg::*;

  logic frame_rst_n;
  logic [RISE_CNT_W-1:0] rise_cnt_q;
  logic [CFG_W-1:0] cfg_shift_q;
  logic cfg_tgl_q;
  logic [FALL_CNT_W-1:0] fall_cnt_q;

  // Counters held clear while trigger high or at conversion end
  assign frame_rst_n = rst_n & ~conv_trigger & ~eoc_clr; // see RQ2

  // Config bit counter on rising edges
  always_ff @(posedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rise_cnt_q <= '0;
    end else if (rise_cnt_q != RISE_DONE) begin
      rise_cnt_q <= rise_cnt_q + 4'h1; // see RQ7 see RQ15
    end
  end

  // Config shift, MSB first
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_shift_q <= CFG_RESET;
    end else if (frame_rst_n && rise_cnt_q != RISE_DONE) begin
      cfg_shift_q <= {cfg_shift_q[CFG_W-2:0], serial_in}; // see RQ22
    end
  end

  // Word complete event only after all bits
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_tgl_q <= 1'b0;
    end else if (frame_rst_n && rise_cnt_q == RISE_DONE - 4'h1) begin
      cfg_tgl_q <= ~cfg_tgl_q; // see RQ8 see RQ16
    end
  end

  // Falling edge count, saturating
  always_ff @(negedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_cnt_q <= '0;
    end else if (fall_cnt_q != FALL_MAX) begin
      fall_cnt_q <= fall_cnt_q + 5'h01;
    end
  end

  assign lnk.cfg_word = cfg_shift_q;
  assign lnk.cfg_tgl = cfg_tgl_q;
  assign lnk.fall_cnt = fall_cnt_q;
endmodule // adcssp_link

/* File: verilog/adcssp_top.sv */
`timescale 1ns/1ps
module adcssp_top #(
  parameter int CONV_CYCLES_P = adcssp_pkg::CONV_CYCLES
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Link clock
  input wire logic serial_clk,
  // Host pins
  input wire logic conv_trigger,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Converter core
  input wire logic [adcssp_pkg::RES_W-1:0] conv_sample,
  output logic [adcssp_pkg::CFG_W-1:0] active_cfg,
  output logic converting,
  output logic conv_done
);
  import adcssp_pkg::*;

  if (CONV_CYCLES_P < 2 || CONV_CYCLES_P >= (1 << CONV_CNT_W)) begin : g_chk
    $error("CONV_CYCLES_P out of range");
  end

  function automatic logic [FALL_CNT_W-1:0] rel_count(input logic busy, input logic rb);
    if (busy) begin
      rel_count = rb ? REL_BUSY_RB : REL_BUSY;
    end else begin
      rel_count = rb ? REL_PLAIN_RB : REL_PLAIN;
    end
  endfunction

  adcssp_link_if lnk ();

  adcssp_state_t state_q;
  logic [CONV_CNT_W-1:0] conv_cnt_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic trig_rise, cfg_evt, eoc;
  logic eoc_q;
  logic [CFG_W-1:0] cfg_new_q;
  logic cfg_pend_q;
  logic [CFG_W-1:0] active_cfg_q;
  logic [CFG_W-1:0] cfg_res_q;
  logic [RES_W-1:0] result_q;
  logic busy_mode_q;
  logic valid_q;
  logic [STREAM_W-1:0] stream;
  logic [FALL_CNT_W-1:0] k;
  logic [FALL_CNT_W-1:0] idx;

  adcssp_link u_link (
    .serial_clk(serial_clk),
    .rst_n(rst_n),
    .conv_trigger(conv_trigger),
    .eoc_clr(eoc_q),
    .serial_in(serial_in),
    .lnk(lnk.link)
  );

  // Trigger synchroniser and edge detect
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else if (clk_en) begin
      trig_s1_q <= conv_trigger;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  // Config-complete toggle synchroniser
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else if (clk_en) begin
      tgl_s1_q <= lnk.cfg_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign trig_rise = trig_s2_q & ~trig_s3_q;
  assign cfg_evt = tgl_s2_q ^ tgl_s3_q;
  assign eoc = (state_q == ST_CONV) && (conv_cnt_q == '0);

  // Conversion sequencer; trigger ignored while converting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      conv_cnt_q <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        ST_IDLE: begin
          if (trig_rise) begin
            state_q <= ST_CONV; // see RQ2
            conv_cnt_q <= CONV_CNT_W'(CONV_CYCLES_P - 1);
          end
        end
        ST_CONV: begin
          if (conv_cnt_q == '0) begin
            state_q <= ST_IDLE;
          end else begin
            conv_cnt_q <= conv_cnt_q - 1'b1; // see RQ3
          end
        end
      endcase
    end
  end

  // End-of-conversion pulse, also clears the link counters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      eoc_q <= 1'b0;
    end else if (clk_en) begin
      eoc_q <= eoc;
    end
  end

  // Completed config word held pending; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_new_q <= CFG_RESET;
      cfg_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (cfg_evt) begin
        cfg_new_q <= lnk.cfg_word; // see RQ22
        cfg_pend_q <= 1'b1;
      end else if (eoc) begin
        cfg_pend_q <= 1'b0;
      end
    end
  end

  // Active config changes only at end of conversion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      active_cfg_q <= CFG_RESET;
    end else if (clk_en && eoc && cfg_pend_q) begin
      active_cfg_q <= cfg_new_q; // see RQ20 see RQ21 see RQ8
    end
  end

  // Result and its config latched at end, replacing any unread one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= RES_RESET;
      cfg_res_q <= CFG_RESET;
      busy_mode_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (clk_en && eoc) begin
      result_q <= conv_sample; // see RQ9
      cfg_res_q <= active_cfg_q; // see RQ11
      busy_mode_q <= ~trig_s2_q; // see RQ14
      valid_q <= 1'b1;
    end
  end

  // Output bit selection from falling edge count
  assign stream = {result_q, cfg_res_q};
  assign k = lnk.fall_cnt;
  assign idx = busy_mode_q ? FALL_CNT_W'(STREAM_W - int'(k)) // see RQ15 see RQ18
                           : FALL_CNT_W'(STREAM_W - 1 - int'(k)); // see RQ5 see RQ7

  always_comb begin
    serial_out = 1'b0;
    if (!(busy_mode_q && k == '0)) begin
      serial_out = stream[idx]; // see RQ11 see RQ19
    end
  end

  // Drive while result held, trigger low, idle and before release edge
  assign serial_out_oe = valid_q && !trig_s2_q && state_q == ST_IDLE && !eoc_q
    && k < rel_count(busy_mode_q, cfg_res_q[CFG_RB_BIT]); // see RQ10 see RQ17 see RQ2

  assign active_cfg = active_cfg_q;
  assign converting = (state_q == ST_CONV);
  assign conv_done = eoc_q;
endmodule // adcssp_top

/* File: verif/adcssp_props.sv */
`timescale 1ns/1ps
module adcssp_props #(
  parameter int CONV_CYCLES_P = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Host pins
  input wire logic serial_clk,
  input wire logic conv_trigger,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // Core side
  input wire logic [adcssp_pkg::RES_W-1:0] conv_sample,
  input wire logic [adcssp_pkg::CFG_W-1:0] active_cfg,
  input wire logic converting,
  input wire logic conv_done
);
  import adcssp_pkg::*;
  logic [11:0] run_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Cycles spent converting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) run_q <= 12'h000;
    else if (clk_en) run_q <= converting ? run_q + 12'h001 : 12'h000;
  end
  sequence busy_eoc_s;
    !conv_trigger [*6] ##0 conv_done;
  endsequence
  sequence plain_eoc_s;
    conv_trigger [*6] ##0 conv_done;
  endsequence
  conv_len_a: assert property ($fell(converting) |-> run_q == CONV_CYCLES_P)
    else $error("conversion length wrong");
  conv_start_a: assert property ($rose(conv_trigger) && !converting && !conv_done
    |-> ##[1:5] converting) else $error("conversion not started");
  conv_quiet_a: assert property (converting || conv_done |-> !serial_out_oe)
    else $error("output driven during conversion");
  trig_release_a: assert property (conv_trigger [*5] |-> !serial_out_oe)
    else $error("output driven with trigger high");
  busy_ready_a: assert property (busy_eoc_s |=> serial_out_oe && !serial_out)
    else $error("no data ready low");
  plain_quiet_a: assert property (plain_eoc_s |=> !serial_out_oe)
    else $error("busy low in plain mode");
  done_pulse_a: assert property (conv_done |=> !conv_done)
    else $error("done longer than one cycle");
  cfg_at_eoc_a: assert property ($changed(active_cfg) |-> conv_done || $past(converting))
    else $error("config changed outside end of conversion");
endmodule // adcssp_props
bind adcssp_top adcssp_props #(.CONV_CYCLES_P(CONV_CYCLES_P)) i_props (.*);

/* File: verif/adcssp_host.sv */
`timescale 1ns/1ps
module adcssp_host (
  // Host pins
  output logic serial_clk,
  output logic conv_trigger,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic pin;
  assign pin = serial_out_oe ? serial_out : 1'h1; // Pull-up on released line
  initial begin
    serial_clk = 1'h0;
    conv_trigger = 1'h0;
    serial_in = 1'h0;
  end
  // Start conversion and wait past its end
  task automatic conv(input bit busy, output logic rdy);
    conv_trigger = 1'h1;
    serial_clk = busy;
    #35;
    if (busy) conv_trigger = 1'h0;
    #265;
    rdy = pin;
  endtask
  // Frame of n falling edges, word on first nc rising, done before next start
  task automatic frame(input bit busy, input int n, input int nc,
      input logic [13:0] c, output logic [31:0] d);
    d = 32'h0;
    serial_in = c[13];
    conv_trigger = 1'h0;
    #40;
    if (!busy) d[0] = pin;
    for (int k = 0; k < 2 * n; k++) begin
      #15 serial_clk = ~serial_clk;
      #2;
      if (serial_clk) serial_in = (k / 2 < nc - 1) ? c[12-k/2] : ~serial_in;
      else d = {d[30:0], pin};
      #13;
    end
  endtask
endmodule // adcssp_host

/* File: verif/test_adc_spanning_serial_port.sv */
`timescale 1ns/1ps
module test_adc_spanning_serial_port;
  import adcssp_pkg::*;
  logic clk_sys, rst_n, serial_clk, conv_trigger, serial_in;
  logic serial_out, serial_out_oe, converting, conv_done, rdy;
  logic [RES_W-1:0] conv_sample;
  logic [CFG_W-1:0] active_cfg;
  logic [31:0] d;
  int n_fail = 0;
  int tests_run = 0;
  adcssp_top #(.CONV_CYCLES_P(8)) i_dut (.*, .clk_en(1'h1));
  adcssp_host i_host (.*);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Two dummy rounds, then result and word read back
  task automatic t_readback();
    repeat (2) begin
      i_host.conv(1'h0, rdy);
      i_host.frame(1'h0, 16, 14, 14'h2A55, d);
    end
    @(negedge clk_sys) conv_sample = 16'hA5C3;
    i_host.conv(1'h0, rdy);
    chk({31'h0, rdy}, 32'h1);
    chk({18'h0, active_cfg}, {18'h0, 14'h2A55});
    i_host.frame(1'h0, 30, 14, 14'h1234, d);
    chk(d, {1'h0, 16'hA5C3, 14'h2A55, 1'h1});
  endtask
  // Short word dropped; plain release at edge 16
  task automatic t_partial();
    i_host.conv(1'h0, rdy);
    chk({18'h0, active_cfg}, {18'h0, 14'h1234});
    i_host.frame(1'h0, 10, 10, 14'h0000, d);
    @(negedge clk_sys) conv_sample = 16'h5A3C;
    i_host.conv(1'h0, rdy);
    chk({18'h0, active_cfg}, {18'h0, 14'h1234});
    i_host.frame(1'h0, 16, 14, 14'h1234, d);
    chk(d, {15'h0, 16'h5A3C, 1'h1});
  endtask
  // Busy mode: ready low, LSB held, release at edge 17
  task automatic t_busy();
    @(negedge clk_sys) conv_sample = 16'h8001;
    i_host.conv(1'h1, rdy);
    chk({31'h0, rdy}, 32'h0);
    i_host.frame(1'h1, 16, 14, 14'h1234, d);
    chk(d, {16'h0, 16'h8001});
    #100;
    chk({30'h0, serial_out_oe, serial_out}, 32'h3);
    @(negedge clk_sys) conv_sample = 16'h7FFE;
    i_host.conv(1'h1, rdy);
    i_host.frame(1'h1, 17, 14, 14'h1234, d);
    chk(d, {15'h0, 16'h7FFE, 1'h1});
  endtask
  // Part-read result is replaced by the next one
  task automatic t_replace();
    @(negedge clk_sys) conv_sample = 16'hC0DE;
    i_host.conv(1'h0, rdy);
    i_host.frame(1'h0, 3, 14, 14'h1234, d);
    chk(d, 32'hC);
    @(negedge clk_sys) conv_sample = 16'h0F0F;
    i_host.conv(1'h0, rdy);
    i_host.frame(1'h0, 16, 14, 14'h1234, d);
    chk(d, {15'h0, 16'h0F0F, 1'h1});
  endtask
  initial begin
    rst_n = 1'h0;
    conv_sample = 16'h0000;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'h1;
    t_readback();
    t_partial();
    t_busy();
    t_replace();
    summarize();
  end
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule // test_adc_spanning_serial_port
